// *** verilog/mlsc_pkg.sv ***
// Package for the modem lead status and control block.
// Assumes a 32-bit APB master and a single 200 MHz clock.
package mlsc_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] STATUS_LOW_OFFS  = 8'h00;
  localparam logic [7:0] STATUS_HIGH_OFFS = 8'h04;
  localparam logic [7:0] CONTROL_OFFS     = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFFS  = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFFS    = 8'h10;
  // ==========================================================
  // Low status byte fields
  localparam int CARRIER_BIT = 0;
  localparam int UNUSED1_BIT = 1;
  localparam int CTS_BIT     = 2;
  localparam int READY_BIT   = 3;
  localparam int HDX_BIT     = 4;
  localparam int RTS_BIT     = 5;
  localparam int DTR_BIT     = 6;
  localparam int RING_BIT    = 7;
  // ==========================================================
  // Upper status byte fields
  localparam int CHAR_MODE_BIT = 0;
  localparam int TEST_MODE_BIT = 2;
  // ==========================================================
  // Control register fields
  localparam int CTL_HDX_BIT  = 0;
  localparam int CTL_RTS_BIT  = 1;
  localparam int CTL_DTR_BIT  = 2;
  localparam int CTL_CHAR_BIT = 3;
  localparam logic [3:0] CONTROL_RESET = 4'h8;
  // ==========================================================
  // Event bits in interrupt status and mask
  localparam int EV_CARRIER = 0;
  localparam int EV_CTS     = 1;
  localparam int EV_READY   = 2;
  localparam int EV_RING    = 3;
  localparam int EV_TEST    = 4;
  localparam int EV_LOSS    = 5;
  localparam int EV_WIDTH   = 6;
  localparam logic [5:0] IRQ_MASK_RESET = 6'h00;
endpackage

// *** verilog/mlsc_edge.sv ***
// Rising and falling edge detector for a vector of modem leads.
// Assumes leads already synchronous to the clock.
`timescale 1ns/1ps
module mlsc_edge #(
  parameter int W = 5
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] lvl_i,
  output logic      [W-1:0] any_o,
  output logic      [W-1:0] fall_o
);
  logic [W-1:0] prev_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= '0;
    end else begin
      prev_q <= lvl_i;
    end
  end

  assign any_o  = prev_q ^ lvl_i;
  assign fall_o = prev_q & ~lvl_i;
endmodule

// *** verilog/mlsc_top.sv ***
// Modem lead status and control registers behind an APB slave.
// Assumes modem leads synchronous to CLK_I and a 32-bit APB master.
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: Low status bit 0 shows the carrier detect lead.
// RQ2: Low status bit 1 always reads zero.
// RQ3: Low status bit 2 shows the clear to send lead.
// RQ4: Bit 3 shows modem ready; its loss flags a fault event.
// RQ5: Bit 4 one means half duplex, zero full duplex.
// RQ6: Bit 5 carries request to send to the modem.
// RQ7: Half duplex modem transmits while request to send is high.
// RQ8: Data moves only after clear to send answers request to send.
// RQ9: Modem drains handed data after request to send falls.
// RQ10: Modem drops clear to send when ready for a new request.
// RQ11: Bit 6 carries data terminal ready to the modem.
// RQ12: Modem disconnects after draining when terminal ready drops.
// RQ13: Bit 7 shows the ring indicator lead.
// RQ14: Modem holds ring on only during ringing segments.
// RQ15: Ring is never gated by data terminal ready.
// RQ16: Host reads all leads and writes the driven ones.
// RQ17: Upper bit 0 is character mode, resetting to one.
// RQ18: Upper bit 2 shows the modem test mode lead.
// RQ19: Request to send and terminal ready read back driven levels.
module mlsc_top (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic [3:0]  PSTRB_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        CARRIER_I,
  input  wire logic        CTS_I,
  input  wire logic        MODEM_READY_I,
  input  wire logic        RING_I,
  input  wire logic        TEST_MODE_I,
  input  wire logic        TX_REQ_I,
  output logic             TX_GO_O,
  output logic             RTS_O,
  output logic             DTR_O,
  output logic             HALF_DUPLEX_O,
  output logic             CHAR_MODE_O,
  output logic             IRQ_O
);
  import mlsc_pkg::*;

  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_WAIT  = 4'b0010,
    TX_SEND  = 4'b0100,
    TX_DRAIN = 4'b1000
  } mlsc_tx_type;

  // ==========================================================
  // Bus decode
  logic            setup_w;
  logic            wr_w;
  logic            rd_w;
  logic            hit_w;
  logic [3:0]      ctl_q;
  logic [EV_WIDTH-1:0] ev_q;
  logic [EV_WIDTH-1:0] mask_q;
  logic [EV_WIDTH-1:0] ev_set_w;
  logic [4:0]      lead_w;
  logic [4:0]      any_w;
  logic [4:0]      fall_w;
  logic [7:0]      low_w;
  logic [7:0]      high_w;
  logic [31:0]     rd_d;
  mlsc_tx_type     tx_q;

  function automatic logic is_reg(input logic [7:0] a);
    is_reg = (a == STATUS_LOW_OFFS) || (a == STATUS_HIGH_OFFS) || (a == CONTROL_OFFS)
          || (a == IRQ_STATUS_OFFS) || (a == IRQ_MASK_OFFS);
  endfunction

  // Zero wait states: answer in the first access cycle
  assign setup_w = PSEL_I && !PENABLE_I;
  assign hit_w   = is_reg(PADDR_I);
  assign wr_w    = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && hit_w && PSTRB_I[0];
  assign rd_w    = PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I && hit_w;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= setup_w;
      PSLVERR_O <= setup_w && !is_reg(PADDR_I);
    end
  end

  // ==========================================================
  // Status bytes
  always_comb begin
    low_w              = 8'h00;                    // [RQ2]
    low_w[CARRIER_BIT] = CARRIER_I;                // [RQ1]
    low_w[CTS_BIT]     = CTS_I;                    // [RQ3]
    low_w[READY_BIT]   = MODEM_READY_I;            // [RQ4]
    low_w[HDX_BIT]     = HALF_DUPLEX_O;            // [RQ5]
    low_w[RTS_BIT]     = RTS_O;                    // [RQ6] [RQ19]
    low_w[DTR_BIT]     = DTR_O;                    // [RQ11] [RQ19]
    low_w[RING_BIT]    = RING_I;                   // [RQ13] [RQ15]
    high_w                = 8'h00;
    high_w[CHAR_MODE_BIT] = CHAR_MODE_O;           // [RQ17]
    high_w[TEST_MODE_BIT] = TEST_MODE_I;           // [RQ18]
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (PADDR_I)
      STATUS_LOW_OFFS:  rd_d = {24'h00_0000, low_w};   // [RQ16]
      STATUS_HIGH_OFFS: rd_d = {24'h00_0000, high_w};
      CONTROL_OFFS:     rd_d = {28'h000_0000, ctl_q};
      IRQ_STATUS_OFFS:  rd_d = {26'h000_0000, ev_q};
      IRQ_MASK_OFFS:    rd_d = {26'h000_0000, mask_q};
      default:          rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (setup_w && !PWRITE_I) begin
      PRDATA_O <= rd_d;
    end
  end

  // ==========================================================
  // Control register; the modem output leads are registered from it one clock later
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ctl_q <= CONTROL_RESET;                      // [RQ17]
    end else if (wr_w && PADDR_I == CONTROL_OFFS) begin
      ctl_q <= PWDATA_I[3:0];                      // [RQ16]
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      RTS_O         <= 1'b0;
      DTR_O         <= 1'b0;
      HALF_DUPLEX_O <= 1'b0;
      CHAR_MODE_O   <= 1'b1;
    end else begin
      RTS_O         <= ctl_q[CTL_RTS_BIT];         // [RQ6]
      DTR_O         <= ctl_q[CTL_DTR_BIT];         // [RQ11]
      HALF_DUPLEX_O <= ctl_q[CTL_HDX_BIT];         // [RQ5]
      CHAR_MODE_O   <= ctl_q[CTL_CHAR_BIT];        // [RQ17]
    end
  end

  // ==========================================================
  // Transmit gate: data only once clear to send answers
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      tx_q <= TX_IDLE;
    end else begin
      unique case (tx_q)
        TX_IDLE:  if (RTS_O) tx_q <= TX_WAIT;
        TX_WAIT:  if (!RTS_O) tx_q <= TX_DRAIN; else if (CTS_I) tx_q <= TX_SEND;   // [RQ8]
        TX_SEND:  if (!RTS_O || !CTS_I) tx_q <= TX_DRAIN;
        // Wait for the modem to drop clear to send before a new request
        TX_DRAIN: if (!CTS_I) tx_q <= TX_IDLE;                                     // [RQ10]
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      TX_GO_O <= 1'b0;
    end else begin
      TX_GO_O <= TX_REQ_I && (tx_q == TX_SEND) && RTS_O && CTS_I;                 // [RQ8]
    end
  end

  // ==========================================================
  // Lead change events
  assign lead_w = {TEST_MODE_I, RING_I, MODEM_READY_I, CTS_I, CARRIER_I};

  mlsc_edge #(.W(5)) u_edge (
    .clk_i  (CLK_I),
    .rst_i  (RST_I),
    .lvl_i  (lead_w),
    .any_o  (any_w),
    .fall_o (fall_w)
  );

  always_comb begin
    ev_set_w             = '0;
    ev_set_w[EV_CARRIER] = any_w[0];
    ev_set_w[EV_CTS]     = any_w[1];
    ev_set_w[EV_READY]   = any_w[2];
    ev_set_w[EV_RING]    = any_w[3] && RING_I;     // [RQ15]
    ev_set_w[EV_TEST]    = any_w[4];
    ev_set_w[EV_LOSS]    = fall_w[2];              // [RQ4]
  end

  // Set wins over the clear-on-read in the same cycle
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ev_q <= '0;
    end else if (rd_w && PADDR_I == IRQ_STATUS_OFFS) begin
      ev_q <= ev_set_w;
    end else begin
      ev_q <= ev_q | ev_set_w;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      mask_q <= IRQ_MASK_RESET;
    end else if (wr_w && PADDR_I == IRQ_MASK_OFFS) begin
      mask_q <= PWDATA_I[EV_WIDTH-1:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(ev_q & mask_q);
    end
  end

  // ==========================================================
  // Checks
  sequence s_rts_up;
    RTS_O && tx_q == TX_IDLE;
  endsequence

  chk_go_needs_cts: assert property (@(posedge CLK_I) disable iff (RST_I)
    TX_GO_O |-> $past(CTS_I) && $past(RTS_O))
    else $error("transmit enabled without clear to send"); // [RQ8]
  chk_rts_to_wait: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_rts_up |=> tx_q == TX_WAIT)
    else $error("request to send not followed by wait"); // [RQ8]
  chk_rts_follows: assert property (@(posedge CLK_I) disable iff (RST_I)
    $changed(ctl_q) |=> RTS_O == $past(ctl_q[CTL_RTS_BIT]) && DTR_O == $past(ctl_q[CTL_DTR_BIT]))
    else $error("driven leads do not follow control"); // [RQ6]
  chk_dtr_readback: assert property (@(posedge CLK_I) disable iff (RST_I)
    low_w[DTR_BIT] == DTR_O && low_w[RTS_BIT] == RTS_O)
    else $error("readback differs from driven lead"); // [RQ19]
  chk_unused_zero: assert property (@(posedge CLK_I) disable iff (RST_I)
    PREADY_O && !PWRITE_I && PADDR_I == STATUS_LOW_OFFS |-> PRDATA_O[UNUSED1_BIT] == 1'b0)
    else $error("unused status bit read as one"); // [RQ2]
  chk_carrier_read: assert property (@(posedge CLK_I) disable iff (RST_I)
    setup_w && !PWRITE_I && PADDR_I == STATUS_LOW_OFFS |=> PRDATA_O[CARRIER_BIT] == $past(CARRIER_I)
      && PRDATA_O[CTS_BIT] == $past(CTS_I) && PRDATA_O[READY_BIT] == $past(MODEM_READY_I))
    else $error("status byte does not show leads"); // [RQ1]
  chk_ring_read: assert property (@(posedge CLK_I) disable iff (RST_I)
    setup_w && !PWRITE_I && PADDR_I == STATUS_LOW_OFFS |=> PRDATA_O[RING_BIT] == $past(RING_I))
    else $error("ring bit not the ring lead"); // [RQ13]
  chk_loss_event: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(MODEM_READY_I) |=> ev_q[EV_LOSS])
    else $error("modem ready loss not flagged"); // [RQ4]
  chk_char_reset: assert property (@(posedge CLK_I)
    $fell(RST_I) |-> CHAR_MODE_O && ctl_q[CTL_CHAR_BIT])
    else $error("character mode not one after reset"); // [RQ17]
  chk_test_read: assert property (@(posedge CLK_I) disable iff (RST_I)
    setup_w && !PWRITE_I && PADDR_I == STATUS_HIGH_OFFS |=> PRDATA_O[TEST_MODE_BIT] == $past(TEST_MODE_I))
    else $error("test mode bit not the lead"); // [RQ18]

  // ==========================================================
  // Bus, register, event and transmit gate checks
  sequence s_low_rd;
    setup_w && !PWRITE_I && PADDR_I == STATUS_LOW_OFFS;
  endsequence
  sequence s_irq_rd;
    rd_w && PADDR_I == IRQ_STATUS_OFFS;
  endsequence

  chk_ready_after_setup: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ16]
    setup_w |=> PREADY_O)
    else $error("no ready after setup");
  chk_ready_one_cycle: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ16]
    PREADY_O |=> !PREADY_O)
    else $error("ready held too long");
  chk_err_unmapped: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ16]
    setup_w && !hit_w |=> PSLVERR_O)
    else $error("unmapped access without error");
  chk_err_with_ready: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ16]
    PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  chk_ctl_write: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ16]
    wr_w && PADDR_I == CONTROL_OFFS |=> ctl_q == $past(PWDATA_I[3:0]))
    else $error("control write lost");
  chk_ctl_nostrobe: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ16]
    PSEL_I && PENABLE_I && PWRITE_I && !PSTRB_I[0] |=> $stable(ctl_q) && $stable(mask_q))
    else $error("write without strobe took effect");
  chk_mode_follows: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ5]
    HALF_DUPLEX_O == $past(ctl_q[CTL_HDX_BIT]) && CHAR_MODE_O == $past(ctl_q[CTL_CHAR_BIT]))
    else $error("mode leads do not follow control");
  chk_ring_ungated: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ15]
    low_w[RING_BIT] == RING_I)
    else $error("ring bit gated");
  chk_hdx_read: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ5]
    low_w[HDX_BIT] == HALF_DUPLEX_O)
    else $error("half duplex bit differs from lead");
  chk_high_unused: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ18]
    PREADY_O && !PWRITE_I && PADDR_I == STATUS_HIGH_OFFS |-> PRDATA_O[7:3] == 5'h00 && !PRDATA_O[1])
    else $error("unused upper bit read as one");
  chk_upper_zero: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ16]
    PREADY_O && !PWRITE_I |-> PRDATA_O[31:8] == 24'h00_0000)
    else $error("read data above byte not zero");
  chk_rts_read: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ19]
    s_low_rd |=> PRDATA_O[RTS_BIT] == $past(RTS_O) && PRDATA_O[DTR_BIT] == $past(DTR_O))
    else $error("driven leads not read back");
  chk_go_needs_req: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ8]
    TX_GO_O |-> $past(TX_REQ_I) && $past(tx_q) == TX_SEND)
    else $error("transmit enabled without request");
  chk_wait_to_send: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ8]
    tx_q == TX_WAIT && RTS_O && CTS_I |=> tx_q == TX_SEND)
    else $error("clear to send not answered");
  chk_send_drop: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ8]
    tx_q == TX_SEND && !RTS_O |=> tx_q == TX_DRAIN)
    else $error("send kept after request dropped");
  chk_drain_idle: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ10]
    tx_q == TX_DRAIN && !CTS_I |=> tx_q == TX_IDLE)
    else $error("drain not ended by clear to send");
  chk_irq_high: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ16]
    (|(ev_q & mask_q)) |=> IRQ_O)
    else $error("interrupt missing");
  chk_irq_low: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ16]
    !(|(ev_q & mask_q)) |=> !IRQ_O)
    else $error("interrupt without cause");
  chk_ev_sticky: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ16]
    !(rd_w && PADDR_I == IRQ_STATUS_OFFS) |=> (ev_q & $past(ev_q)) == $past(ev_q))
    else $error("event bit lost without read");
  chk_read_clears: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ16]
    s_irq_rd |=> ev_q == $past(ev_set_w))
    else $error("status read did not clear");
  chk_ring_event: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ13]
    $rose(RING_I) |=> ev_q[EV_RING])
    else $error("ring rise not flagged");
  chk_cts_event: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ3]
    $changed(CTS_I) |=> ev_q[EV_CTS])
    else $error("clear to send change not flagged");
endmodule

// *** testbench/mlsc_modem.sv ***
// Behavioural local modem facing the modem leads.
// Assumes leads sampled on clk_i; tb drives ring and test requests.
`timescale 1ns/1ps
module mlsc_modem (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic rts_i,
  input  wire logic dtr_i,
  input  wire logic slow_i,
  input  wire logic ring_req_i,
  input  wire logic test_req_i,
  output logic      cts_o,
  output logic      carrier_o,
  output logic      ready_o,
  output logic      ring_o,
  output logic      test_o
);
  logic [3:0] cnt_q;
  // ==========================================
  // Clear to send handshake; transmit mode follows rts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cts_o <= 1'b0;
      cnt_q <= 4'h0;
    end else if (rts_i && !cts_o) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == (slow_i ? 4'h6 : 4'h1)) begin
        cts_o <= 1'b1;
        cnt_q <= 4'h0;
      end
    end else if (!rts_i && cts_o) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == 4'h3) begin
        cts_o <= 1'b0;
        cnt_q <= 4'h0;
      end
    end else begin
      cnt_q <= 4'h0;
    end
  end
  // ==========================================
  // Line connection; drop waits for drain to end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_o   <= 1'b0;
      carrier_o <= 1'b0;
    end else begin
      ready_o   <= dtr_i | (ready_o & cts_o);
      carrier_o <= ready_o;
    end
  end
  // ==========================================
  // Ring and test follow requests, never dtr
  always_ff @(posedge clk_i) begin
    ring_o <= !rst_i && ring_req_i;
    test_o <= !rst_i && test_req_i;
  end
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the modem lead block.
// Assumes an APB slave ready within 50 cycles and the modem model beside it.
`timescale 1ns/1ps
module tb;
  import mlsc_pkg::*;
  logic        clk, rst, psel, pen, pwr, txr, slow, rreq, treq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  logic        pready, perr, cts, car, rdy, ring, test, go, rts, dtr, hdx, chr, irq, e;
  int          errors, num_checks, cyc;
  mlsc_top uut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(perr), .CARRIER_I(car), .CTS_I(cts), .MODEM_READY_I(rdy), .RING_I(ring),
    .TEST_MODE_I(test), .TX_REQ_I(txr), .TX_GO_O(go), .RTS_O(rts), .DTR_O(dtr),
    .HALF_DUPLEX_O(hdx), .CHAR_MODE_O(chr), .IRQ_O(irq));
  mlsc_modem modem (.clk_i(clk), .rst_i(rst), .rts_i(rts), .dtr_i(dtr), .slow_i(slow),
    .ring_req_i(rreq), .test_req_i(treq), .cts_o(cts), .carrier_o(car), .ready_o(rdy),
    .ring_o(ring), .test_o(test));
  // ==========================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask
  // ==========================================
  // APB master; waits for pready, never assumes
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) errors++;
    r = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic t_reset();
    chk("char out", chr, 1);
    apb(0, STATUS_HIGH_OFFS, 0);
    chk("upper", r, 1);
    apb(0, 8'h14, 0);
    chk("unmapped err", {r[30:0], e}, 1);
  endtask
  task automatic t_ctl();
    pstrb <= 4'h0;
    apb(1, CONTROL_OFFS, 32'hD);
    pstrb <= 4'hF;
    apb(0, CONTROL_OFFS, 0);
    chk("ctl no strobe", r, 32'h8);
    apb(1, CONTROL_OFFS, 32'hD);
    repeat (6) @(posedge clk);
    chk("dtr hdx", {dtr, hdx}, 3);
    apb(0, STATUS_LOW_OFFS, 0);
    chk("status dtr", r, 32'h59);
  endtask
  task automatic t_hs();
    int n;
    slow <= 1'b1;
    txr <= 1'b1;
    apb(1, CONTROL_OFFS, 32'hF);
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (go === 1'b1) chk("cts at go", cts, 1);
    end while (go !== 1'b1 && n < 40);
    chk("go", go, 1);
    apb(0, STATUS_LOW_OFFS, 0);
    chk("status rts", r, 32'h7D);
    apb(1, CONTROL_OFFS, 32'hD);
    repeat (10) @(posedge clk);
    chk("go off", go, 0);
    apb(0, STATUS_LOW_OFFS, 0);
    chk("status drop", r, 32'h59);
    txr <= 1'b0;
  endtask
  task automatic t_ring();
    apb(1, CONTROL_OFFS, 32'h8);
    apb(1, IRQ_MASK_OFFS, 32'h1 << EV_RING);
    apb(0, IRQ_STATUS_OFFS, 0);
    rreq <= 1'b1;
    repeat (4) @(posedge clk);
    chk("irq", irq, 1);
    apb(0, STATUS_LOW_OFFS, 0);
    chk("ring no dtr", r[7:6], 2);
    apb(0, IRQ_STATUS_OFFS, 0);
    chk("irq ring", r[EV_RING], 1);
    repeat (3) @(posedge clk);
    chk("irq clr", irq, 0);
    rreq <= 1'b0;
    apb(1, IRQ_MASK_OFFS, 0);
    rreq <= 1'b1;
    repeat (4) @(posedge clk);
    chk("irq masked", irq, 0);
    rreq <= 1'b0;
  endtask
  task automatic t_test();
    treq <= 1'b1;
    repeat (4) @(posedge clk);
    apb(0, STATUS_HIGH_OFFS, 0);
    chk("upper test", r, 32'h5);
    apb(1, CONTROL_OFFS, 0);
    repeat (2) @(posedge clk);
    chk("char off", chr, 0);
    apb(0, STATUS_HIGH_OFFS, 0);
    chk("upper bit", r, 32'h4);
  endtask
  initial begin
    {rst, psel, pen, pwr, txr, slow, rreq, treq, e} = 9'h100;
    {paddr, pwdata, r, pstrb} = 76'hF;
    {errors, num_checks, cyc} = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_ctl();
    t_hs();
    t_ring();
    t_test();
    print_verdict();
  end
endmodule
